// *** hdl/cnm_perm.sv ***
// Purpose: traffic permissions and state code from the nmt state
// Assumes: state changes on the same clock as the caller
// Notes:   registered so the caller can pass it straight to outputs
`default_nettype none
module cnm_perm
    import cnm_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst_b,
    input  wire cnm_state_e state,
    input  wire logic       can_on,
    output cnm_perm_s       perm,
    output logic [6:0]      code
);
    // permissions; only dictionary writes pass before the id enables frame processing
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            perm <= '0;
        end else begin
            case (state)
                CNM_PREOP: perm <= '{nmt: can_on, sdo: can_on, pdo: 1'b0, dict_wr: 1'b1};
                CNM_OPER:  perm <= '{nmt: can_on, sdo: can_on, pdo: can_on, dict_wr: 1'b0};
                CNM_STOP:  perm <= '{nmt: can_on, sdo: 1'b0, pdo: 1'b0, dict_wr: 1'b0};
                default:   perm <= '{nmt: 1'b0, sdo: 1'b0, pdo: 1'b0, dict_wr: 1'b1};
            endcase
        end
    end

    // outward state code
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            code <= CODE_INIT;
        end else begin
            case (state)
                CNM_PREOP: code <= CODE_PREOP;
                CNM_OPER:  code <= CODE_OPER;
                CNM_STOP:  code <= CODE_STOP;
                default:   code <= CODE_INIT;
            endcase
        end
    end
endmodule
`default_nettype wire

// *** hdl/cnm_pkg.sv ***
// Purpose: shared constants and carrier types for the node identity and nmt control block
// Assumes: one command at a time from the node's command interface
// Notes:   nmt transmit frames leave through a one-entry transmit slot
// Operation
// - first accepted identity command stores id, enables can, initializes all cob-ids
// - identity command refused with command error while operational or stopped
// - after id set, positive only replaces id; negative sets magnitude and reinitializes
// - zero parameter takes lower seven serial id bits as node id
// - serial-derived id of zero raises command error; zero means broadcast
// - explicit id 1..127 sets id; initializes communication parameters only on first set
// - local request 1 operational, 2 stopped, 128 pre-op, 130 reset comms then pre-op
// - state codes are 127 pre-operational, 5 operational, 4 stopped
// - pre-operational allows nmt, sdo, dictionary writes; blocks pdo
// - operational allows nmt, sdo and pdo traffic
// - stopped allows only nmt traffic
// - reset comms restores default cob-ids then enters pre-operational
// - remote request 129 resets targeted nodes, which return to pre-operational
// - during node reset the node falls back to single-drop serial operation
// - remote target 0 is broadcast, 1..127 addresses a single node
// - remote command ends zero-only when slot free with target 0..127 and can on, negative-only when pending
// - single nmt master, no acknowledge; heartbeat reports new state next time
// - local command moves to requested state, not state equal to request value
// - normal completion sets zero flag and clears positive and negative flags
`default_nettype none
package cnm_pkg;
    // command opcodes
    localparam logic [7:0]  OP_SET_ID      = 8'h49;
    localparam logic [7:0]  OP_LOCAL_NMT   = 8'h4a;
    localparam logic [7:0]  OP_REMOTE_NMT  = 8'h51;
    // transition request values
    localparam logic [15:0] REQ_OPER       = 16'h0001;
    localparam logic [15:0] REQ_STOP       = 16'h0002;
    localparam logic [15:0] REQ_PREOP      = 16'h0080;
    localparam logic [15:0] REQ_RST_NODE   = 16'h0081;
    localparam logic [15:0] REQ_RST_COMM   = 16'h0082;
    // state codes reported outward
    localparam logic [6:0]  CODE_PREOP     = 7'h7f;
    localparam logic [6:0]  CODE_OPER      = 7'h05;
    localparam logic [6:0]  CODE_STOP      = 7'h04;
    localparam logic [6:0]  CODE_INIT      = 7'h00;
    localparam logic [6:0]  ID_BROADCAST   = 7'h00;
    localparam logic [6:0]  ID_MAX         = 7'h7f;
    localparam int          ID_BITS        = 7;
    // time the node stays in serial fallback after a reset-node request, in ns and in cycles
    localparam int          RESET_NODE_NS  = 10000;
    localparam int          CLK_NS         = 20;
    localparam int          RESET_NODE_CYC = RESET_NODE_NS / CLK_NS;

    typedef enum logic [1:0] {
        CNM_INIT,
        CNM_PREOP,
        CNM_OPER,
        CNM_STOP
    } cnm_state_e;

    // command from the command / program interface
    typedef struct packed {
        logic [7:0]  opcode;
        logic [15:0] arg0;
        logic [15:0] arg1;
    } cnm_cmd_s;

    // completion flags of the internal status word
    typedef struct packed {
        logic cmd_err;
        logic pos;
        logic zero;
        logic neg;
    } cnm_flags_s;

    // nmt frame handed to the can transmitter
    typedef struct packed {
        logic [7:0] cmd;
        logic [6:0] target;
    } cnm_nmt_frame_s;

    // traffic permissions for the can engine
    typedef struct packed {
        logic nmt;
        logic sdo;
        logic pdo;
        logic dict_wr;
    } cnm_perm_s;
endpackage
`default_nettype wire

// *** hdl/cnm_sync.sv ***
// Purpose: two-flop synchroniser for pin-side levels
// Assumes: input is a slow level
// Notes:   first stage feeds only the second
`default_nettype none
module cnm_sync
    import cnm_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] d,
    output logic [W-1:0]      q
);
    logic [W-1:0] meta;

    // metastability guard
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule
`default_nettype wire

// *** hdl/cnm_top.sv ***
// Purpose: node identity and nmt state control
// Assumes: cmd_valid is a one-cycle pulse from same-clock logic
// Notes:   serial id comes from pins and is synchronised
`default_nettype none
module cnm_top
    import cnm_pkg::*;
#(
    parameter int RESET_CYC = RESET_NODE_CYC
) (
    input  wire logic           mclk,
    input  wire logic           rst_b,
    input  wire logic           cmd_valid,
    input  wire cnm_cmd_s       cmd,
    input  wire logic [7:0]     serial_id,
    input  wire logic           nmt_tx_done,
    output logic                cmd_done,
    output cnm_flags_s          flags,
    output logic [6:0]          node_id,
    output logic                can_on,
    output logic                cobid_init,
    output logic                nmt_tx_valid,
    output cnm_nmt_frame_s      nmt_tx,
    output cnm_perm_s           perm,
    output logic [6:0]          state_code,
    output logic                serial_fallback,
    output logic                hb_update
);
    cnm_state_e      state;
    cnm_state_e      next_state;
    logic [7:0]      serial_q;
    logic            id_set;
    logic [6:0]      derived_id;
    logic [15:0]     id_mag;
    logic            id_ok;
    logic            req_ok;
    logic            rst_busy;
    logic [31:0]     rst_cnt;
    logic            go_rst_node;
    logic            slot_busy;
    logic            local_ok;

    cnm_sync #(
        .W (8)
    ) u_sync (
        .mclk  (mclk),
        .rst_b (rst_b),
        .d     (serial_id),
        .q     (serial_q)
    );

    cnm_perm u_perm (
        .mclk   (mclk),
        .rst_b  (rst_b),
        .state  (state),
        .can_on (can_on),
        .perm   (perm),
        .code   (state_code)
    );

    // magnitude of a signed 16-bit id argument
    function automatic logic [15:0] mag16(input logic [15:0] v);
        mag16 = v[15] ? 16'(-v) : v;
    endfunction

    // identity argument decode
    always_comb begin
        derived_id = serial_q[ID_BITS-1:0];
        id_mag     = mag16(cmd.arg0);
        if (cmd.arg0 == 16'h0000) begin
            id_ok = (derived_id != ID_BROADCAST);
        end else begin
            id_ok = (id_mag <= 16'(ID_MAX));
        end
    end

    // local request decode; only documented values pass
    always_comb begin
        req_ok     = 1'b1;
        next_state = state;
        case (cmd.arg0)
            REQ_OPER:     next_state = CNM_OPER;
            REQ_STOP:     next_state = CNM_STOP;
            REQ_PREOP:    next_state = CNM_PREOP;
            REQ_RST_COMM: next_state = CNM_PREOP;
            default:      req_ok     = 1'b0;
        endcase
    end

    // local transitions wait until can is running
    assign local_ok    = req_ok && (state != CNM_INIT);
    assign slot_busy   = nmt_tx_valid;
    // a reset-node request only counts when the frame itself is accepted
    assign go_rst_node = cmd_valid && !rst_busy && cmd.opcode == OP_REMOTE_NMT && !slot_busy
                         && can_on && cmd.arg0 <= 16'(ID_MAX) && cmd.arg1 == REQ_RST_NODE;

    // nmt state
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state <= CNM_INIT;
        end else if (rst_busy && rst_cnt == 32'd1) begin
            state <= CNM_PREOP;
        end else if (cmd_valid && !rst_busy) begin
            case (cmd.opcode)
                OP_SET_ID: begin
                    if (id_ok && state == CNM_INIT) begin
                        state <= CNM_PREOP;
                    end
                end
                OP_LOCAL_NMT: begin
                    if (local_ok) begin
                        state <= next_state;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // node identity and frame enable
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            node_id <= ID_BROADCAST;
            id_set  <= 1'b0;
            can_on  <= 1'b0;
        end else if (cmd_valid && !rst_busy && cmd.opcode == OP_SET_ID && id_ok
                     && (state == CNM_PREOP || state == CNM_INIT)) begin
            node_id <= (cmd.arg0 == 16'h0000) ? derived_id : id_mag[ID_BITS-1:0];
            id_set  <= 1'b1;
            can_on  <= 1'b1;
        end
    end

    // one-cycle pulse that reloads default cob-ids
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cobid_init <= 1'b0;
        end else begin
            cobid_init <= 1'b0;
            if (cmd_valid && !rst_busy) begin
                if (cmd.opcode == OP_SET_ID && id_ok
                    && (state == CNM_PREOP || state == CNM_INIT)) begin
                    // first set, serial-derived id before set, or negated id forces reload
                    cobid_init <= !id_set || cmd.arg0[15] || cmd.arg0 == 16'h0000
                                  && !id_set;
                end else if (cmd.opcode == OP_LOCAL_NMT && local_ok
                             && cmd.arg0 == REQ_RST_COMM) begin
                    cobid_init <= 1'b1;
                end
            end
        end
    end

    // nmt transmit slot; new frame is refused while the earlier one is pending
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            nmt_tx_valid <= 1'b0;
            nmt_tx       <= '0;
        end else if (cmd_valid && !rst_busy && cmd.opcode == OP_REMOTE_NMT && !slot_busy
                     && cmd.arg0 <= 16'(ID_MAX) && can_on) begin
            nmt_tx_valid <= 1'b1;
            nmt_tx       <= '{cmd: cmd.arg1[7:0], target: cmd.arg0[ID_BITS-1:0]};
        end else if (nmt_tx_done) begin
            nmt_tx_valid <= 1'b0;
        end
    end

    // reset-node: local node also falls back to serial for a while
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_busy        <= 1'b0;
            rst_cnt         <= '0;
            serial_fallback <= 1'b0;
        end else if (go_rst_node && (cmd.arg0 == 16'(ID_BROADCAST)
                                     || cmd.arg0[ID_BITS-1:0] == node_id)) begin
            rst_busy        <= 1'b1;
            rst_cnt         <= 32'(RESET_CYC);
            serial_fallback <= 1'b1;
        end else if (rst_busy) begin
            rst_cnt <= rst_cnt - 32'd1;
            if (rst_cnt == 32'd1) begin
                rst_busy        <= 1'b0;
                serial_fallback <= 1'b0;
            end
        end
    end

    // completion flags; heartbeat pulse when state moves, except out of init
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_done  <= 1'b0;
            flags     <= '0;
            hb_update <= 1'b0;
        end else begin
            cmd_done  <= 1'b0;
            hb_update <= (state_code != CODE_INIT) && (state == CNM_OPER
                         ? state_code != CODE_OPER : state == CNM_STOP
                         ? state_code != CODE_STOP : state_code != CODE_PREOP);
            if (cmd_valid && !rst_busy) begin
                cmd_done <= 1'b1;
                case (cmd.opcode)
                    OP_SET_ID: begin
                        if (id_ok && (state == CNM_PREOP || state == CNM_INIT)) begin
                            flags <= '{cmd_err: 1'b0, pos: 1'b0, zero: 1'b1, neg: 1'b0};
                        end else begin
                            flags <= '{cmd_err: 1'b1, pos: 1'b0, zero: 1'b0, neg: 1'b0};
                        end
                    end
                    OP_LOCAL_NMT: begin
                        if (local_ok) begin
                            flags <= '{cmd_err: 1'b0, pos: 1'b0, zero: 1'b1, neg: 1'b0};
                        end else begin
                            flags <= '{cmd_err: 1'b1, pos: 1'b0, zero: 1'b0, neg: 1'b0};
                        end
                    end
                    OP_REMOTE_NMT: begin
                        if (slot_busy) begin
                            flags <= '{cmd_err: 1'b0, pos: 1'b0, zero: 1'b0, neg: 1'b1};
                        end else if (cmd.arg0 <= 16'(ID_MAX) && can_on) begin
                            flags <= '{cmd_err: 1'b0, pos: 1'b0, zero: 1'b1, neg: 1'b0};
                        end else begin
                            flags <= '{cmd_err: 1'b1, pos: 1'b0, zero: 1'b0, neg: 1'b0};
                        end
                    end
                    default: begin
                        cmd_done <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// *** test/cnm_can_tx_model.sv ***
// Purpose: can transmitter that frees the nmt slot
// Assumes: slot request is a level until done
// Notes:   stall holds the frame to model a busy bus
`default_nettype none
module cnm_can_tx_model
    import cnm_pkg::*;
(
    input  wire logic           mclk,
    input  wire logic           rst_b,
    input  wire logic           nmt_tx_valid,
    input  wire cnm_nmt_frame_s nmt_tx,
    input  wire logic           stall,
    output var  logic           nmt_tx_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] cnt;
    // sends after a few cycles; consumers never acknowledge, so done is ours alone
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cnt         <= 3'h0;
            nmt_tx_done <= 1'b0;
        end else if (nmt_tx_done || !nmt_tx_valid) begin
            cnt         <= 3'h0;
            nmt_tx_done <= 1'b0;
        end else if (cnt == 3'h3 && !stall) begin
            nmt_tx_done <= 1'b1;
        end else if (cnt != 3'h3) begin
            cnt <= cnt + 3'h1;
        end
    end
endmodule
`default_nettype wire

// *** test/cnm_top_properties.sv ***
// Purpose: port checks for node identity and nmt control
// Assumes: state_code and perm trail the internal state by one cycle
// Notes:   quiet excludes cycles where state_code may still catch up
`default_nettype none
module cnm_top_properties
    import cnm_pkg::*;
#(
    parameter int RESET_CYC = 4
) (
    input wire logic           mclk,
    input wire logic           rst_b,
    input wire logic           cmd_valid,
    input wire cnm_cmd_s       cmd,
    input wire logic [7:0]     serial_id,
    input wire logic           nmt_tx_done,
    input wire logic           cmd_done,
    input wire cnm_flags_s     flags,
    input wire logic [6:0]     node_id,
    input wire logic           can_on,
    input wire logic           cobid_init,
    input wire logic           nmt_tx_valid,
    input wire cnm_nmt_frame_s nmt_tx,
    input wire cnm_perm_s      perm,
    input wire logic [6:0]     state_code,
    input wire logic           serial_fallback,
    input wire logic           hb_update
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // taken command and settled state
    wire logic tk    = cmd_valid && !serial_fallback;
    wire logic quiet = !cmd_done && !hb_update;
    wire logic ok_rq = cmd.arg0 inside {REQ_OPER, REQ_STOP, REQ_PREOP, REQ_RST_COMM};
    wire logic open  = state_code inside {CODE_INIT, CODE_PREOP};
    function automatic logic [6:0] code_of(input logic [15:0] r);
        return (r == REQ_OPER) ? CODE_OPER : (r == REQ_STOP) ? CODE_STOP : CODE_PREOP;
    endfunction
    sequence s_ok;
        cmd_done && flags == 4'h2;
    endsequence
    sequence s_err;
        cmd_done && flags.cmd_err;
    endsequence
    property p_local_ok;
        tk && cmd.opcode == OP_LOCAL_NMT && ok_rq && state_code != CODE_INIT && quiet
        |=> s_ok ##1 state_code == code_of($past(cmd.arg0, 2));
    endproperty
    a_local_ok: assert property (p_local_ok) else $error("local request wrong state");
    property p_local_bad;
        tk && cmd.opcode == OP_LOCAL_NMT && !ok_rq && quiet |=> s_err ##1 $stable(state_code);
    endproperty
    a_local_bad: assert property (p_local_bad) else $error("bad request not refused");
    property p_id_refused;
        tk && cmd.opcode == OP_SET_ID && !open && quiet |=> s_err and $stable(node_id);
    endproperty
    a_id_refused: assert property (p_id_refused) else $error("id taken in oper or stop");
    property p_id_pos;
        tk && cmd.opcode == OP_SET_ID && cmd.arg0 inside {[1:127]} && open && quiet
        |=> s_ok and (can_on && node_id == $past(cmd.arg0[6:0]));
    endproperty
    a_id_pos: assert property (p_id_pos) else $error("explicit id not set");
    property p_id_neg;
        tk && cmd.opcode == OP_SET_ID && cmd.arg0 inside {[16'hff81:16'hffff]} && open && quiet
        |=> s_ok and (cobid_init && node_id == 7'(16'h0 - $past(cmd.arg0)));
    endproperty
    a_id_neg: assert property (p_id_neg) else $error("negative id wrong");
    property p_first_id;
        (tk && cmd.opcode == OP_SET_ID && !can_on) ##1 s_ok |-> cobid_init && can_on;
    endproperty
    a_first_id: assert property (p_first_id) else $error("first id did not start can");
    property p_remote_ok;
        tk && cmd.opcode == OP_REMOTE_NMT && can_on && !nmt_tx_valid && cmd.arg0 < 16'h80
        |=> s_ok and (nmt_tx_valid && nmt_tx == {$past(cmd.arg1[7:0]), $past(cmd.arg0[6:0])});
    endproperty
    a_remote_ok: assert property (p_remote_ok) else $error("remote frame wrong");
    property p_remote_busy;
        tk && cmd.opcode == OP_REMOTE_NMT && can_on && nmt_tx_valid && !nmt_tx_done
        && cmd.arg0 < 16'h80 |=> cmd_done && flags == 4'h1 && $stable(nmt_tx);
    endproperty
    a_remote_busy: assert property (p_remote_busy) else $error("pending slot not flagged");
    property p_preop;
        state_code == CODE_PREOP |-> perm == 4'hd;
    endproperty
    a_preop: assert property (p_preop) else $error("preop traffic wrong");
    property p_oper;
        state_code == CODE_OPER |-> perm.nmt && perm.sdo && perm.pdo;
    endproperty
    a_oper: assert property (p_oper) else $error("oper traffic wrong");
    property p_stop;
        state_code == CODE_STOP |-> perm == 4'h8;
    endproperty
    a_stop: assert property (p_stop) else $error("stop traffic wrong");
    // a state code change out of a running state must show in the next heartbeat
    property p_hb;
        $changed(state_code) && $past(state_code) != CODE_INIT |-> hb_update;
    endproperty
    a_hb: assert property (p_hb) else $error("state change without heartbeat");
endmodule
`default_nettype wire

// *** test/cnm_top_tb.sv ***
// Purpose: self-checking bench for node identity and nmt control
// Assumes: inputs change on the falling edge
// Notes:   fallback shortened through RESET_CYC
`default_nettype none
module cnm_top_tb import cnm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] RQ [5] = '{16'h1, 16'h2, 16'h80, 16'h82, 16'h3};
    localparam logic [6:0]  CD [5] = '{7'h05, 7'h04, 7'h7f, 7'h7f, 7'h7f};
    localparam logic [2:0]  PM [5] = '{3'h7, 3'h4, 3'h6, 3'h6, 3'h6};
    logic           mclk = 1'b0, rst_b = 1'b0, cmd_valid = 1'b0, stall = 1'b1;
    logic [7:0]     serial_id = 8'h80;
    cnm_cmd_s       cmd = '0;
    logic           cmd_done, can_on, cobid_init, nmt_tx_valid, nmt_tx_done;
    logic           serial_fallback, hb_update;
    cnm_flags_s     flags;
    logic [6:0]     node_id, state_code;
    cnm_nmt_frame_s nmt_tx;
    cnm_perm_s      perm;
    int             errors = 0, n_checks = 0, cyc = 0;
    always #10 mclk = ~mclk;
    // cut a hang short
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            errors++;
            conclude();
        end
    end
    cnm_top #(.RESET_CYC(20)) i_cnm_top (.mclk(mclk), .rst_b(rst_b), .cmd_valid(cmd_valid),
        .cmd(cmd), .serial_id(serial_id), .nmt_tx_done(nmt_tx_done), .cmd_done(cmd_done),
        .flags(flags), .node_id(node_id), .can_on(can_on), .cobid_init(cobid_init),
        .nmt_tx_valid(nmt_tx_valid), .nmt_tx(nmt_tx), .perm(perm), .state_code(state_code),
        .serial_fallback(serial_fallback), .hb_update(hb_update));
    cnm_can_tx_model i_cnm_can_tx_model (.mclk(mclk), .rst_b(rst_b),
        .nmt_tx_valid(nmt_tx_valid), .nmt_tx(nmt_tx), .stall(stall), .nmt_tx_done(nmt_tx_done));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            errors++;
        end
    endtask
    // one-cycle strobe; returns where first-cycle answers have settled
    task automatic send(input logic [7:0] op, input logic [15:0] a0, input logic [15:0] a1);
        @(negedge mclk);
        cmd_valid = 1'b1;
        cmd = '{op, a0, a1};
        @(negedge mclk);
        cmd_valid = 1'b0;
    endtask
    task automatic t_ident;
        chk(16'(state_code), 16'(CODE_INIT));
        send(OP_LOCAL_NMT, REQ_OPER, 16'h0);
        chk(16'(flags), 16'h8);
        send(OP_SET_ID, 16'h0, 16'h0);
        chk(16'(flags), 16'h8);
        chk(16'(can_on), 16'h0);
        serial_id = 8'h85;
        repeat (3) @(negedge mclk);
        send(OP_SET_ID, 16'h0, 16'h0);
        chk(16'(node_id), 16'h5);
        chk(16'({can_on, cobid_init}), 16'h3);
        chk(16'(flags), 16'h2);
        @(negedge mclk);
        chk(16'({state_code, perm}), 16'h7fd);
        send(OP_SET_ID, 16'h9, 16'h0);
        chk(16'({node_id, cobid_init}), 16'h12);
        send(OP_SET_ID, 16'hfffd, 16'h0);
        chk(16'({node_id, cobid_init}), 16'h7);
        send(OP_SET_ID, 16'h7f, 16'h0);
        chk(16'({node_id, flags}), 16'h7f2);
        send(OP_SET_ID, 16'h80, 16'h0);
        chk(16'(flags), 16'h8);
        $display("test ident finished");
    endtask
    task automatic t_local;
        for (int i = 0; i < 5; i++) begin
            send(OP_LOCAL_NMT, RQ[i], 16'h0);
            chk(16'(flags), (i < 4) ? 16'h2 : 16'h8);
            chk(16'(cobid_init), 16'(RQ[i] == REQ_RST_COMM));
            @(negedge mclk);
            chk(16'(state_code), 16'(CD[i]));
            chk(16'(perm[3:1]), 16'(PM[i]));
            if (CD[i] != CODE_PREOP) begin
                send(OP_SET_ID, 16'h5, 16'h0);
                chk(16'({node_id, flags}), 16'h7f8);
            end
        end
        $display("test local finished");
    endtask
    task automatic t_remote;
        send(OP_LOCAL_NMT, REQ_OPER, 16'h0);
        chk(16'(flags), 16'h2);
        send(OP_REMOTE_NMT, 16'h80, REQ_OPER);
        chk(16'({nmt_tx_valid, flags}), 16'h08);
        send(OP_REMOTE_NMT, 16'h10, REQ_OPER);
        chk(16'({nmt_tx_valid, flags}), 16'h12);
        chk(16'(nmt_tx), 16'h0090);
        send(OP_REMOTE_NMT, 16'h0, REQ_STOP);
        chk(16'({nmt_tx, flags}), 16'h0901);
        stall = 1'b0;
        for (int i = 0; i < 6; i++) begin
            for (int k = 0; k < 40 && nmt_tx_valid; k++) @(negedge mclk);
            if (i == 5) break;
            send(OP_REMOTE_NMT, (i == 4) ? 16'h0 : 16'h10, (i == 4) ? REQ_RST_NODE : RQ[i]);
            chk(16'(flags), 16'h2);
            chk(16'(nmt_tx), (i == 4) ? 16'h4080 : {1'b0, RQ[i][7:0], 7'h10});
        end
        for (int k = 0; k < 10 && !serial_fallback; k++) @(negedge mclk);
        chk(16'(serial_fallback), 16'h1);
        send(OP_SET_ID, 16'h5, 16'h0);
        chk(16'(cmd_done), 16'h0);
        for (int k = 0; k < 60 && serial_fallback; k++) @(negedge mclk);
        repeat (2) @(negedge mclk);
        chk(16'({serial_fallback, state_code}), 16'h7f);
        $display("test remote finished");
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (20) @(negedge mclk);
        rst_b = 1'b1;
        t_ident();
        t_local();
        t_remote();
        conclude();
    end
endmodule
bind cnm_top cnm_top_properties #(.RESET_CYC(RESET_CYC)) i_cnm_top_properties (.mclk(mclk),
    .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd(cmd), .serial_id(serial_id),
    .nmt_tx_done(nmt_tx_done), .cmd_done(cmd_done), .flags(flags), .node_id(node_id),
    .can_on(can_on), .cobid_init(cobid_init), .nmt_tx_valid(nmt_tx_valid), .nmt_tx(nmt_tx),
    .perm(perm), .state_code(state_code), .serial_fallback(serial_fallback),
    .hb_update(hb_update));
`default_nettype wire
